// >>> rtl/pcslt_pkg.sv
// Package of constants for the PC card slot control register bank.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`default_nettype none
package pcslt_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int CSC_W = 4;
  localparam int WORD_LSB = 2;
  // Byte offsets of the registers.
  localparam logic [8:0] OFS_IDENT = 9'h000;
  localparam logic [8:0] OFS_POWER = 9'h008;
  localparam logic [8:0] OFS_CSC = 9'h010;
  localparam logic [8:0] OFS_ADD_GEN = 9'h058;
  localparam logic [8:0] OFS_FIXED = 9'h05c;
  localparam logic [8:0] OFS_GLOBAL = 9'h078;
  localparam logic [8:0] OFS_TIMING = 9'h0ec;
  localparam logic [8:0] OFS_SPARE = 9'h0f0;
  localparam logic [8:0] OFS_FUNC_SEL = 9'h0f8;
  localparam logic [8:0] OFS_SPECIAL = 9'h0fc;
  localparam logic [8:0] OFS_SLOT_EN = 9'h100;
  localparam logic [8:0] OFS_BUF_DIS = 9'h104;
  localparam logic [8:0] OFS_DETECT = 9'h108;
  localparam logic [8:0] OFS_COMMON_PWR = 9'h10c;
  localparam logic [8:0] OFS_SLOT_LAST = 9'h0fc;
  // Fixed read and reset values.
  localparam logic [7:0] FIXED_VALUE = 8'h0f;
  localparam logic [7:0] RD_ZERO = 8'h00;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] IDENT_RESET = 8'h5a; // Arbitrary value.
  // Field positions.
  localparam int GC_EXPLICIT_WB = 2;
  localparam int PWR_VCC_3V = 3;
  localparam int AG_VS_LO = 6;
  localparam int AG_VS_HI = 7;
  localparam int TM_ENABLED = 7;
  localparam int TM_SETUP_LO = 4;
  localparam int TM_SETUP_HI = 5;
  localparam int TM_HOLD_LO = 0;
  localparam int TM_HOLD_HI = 3;
  localparam int FS_BUF_PWR_EN = 6;
  localparam int FS_TIMING_EN = 3;
  localparam int FS_VS_EN = 1;
  localparam int FS_CARD_PWR_EN = 0;
  localparam int SO_PULSE_MODE = 2;
  localparam int SO_REMOVAL = 1;
  localparam int SO_BUF_CTRL = 0;
  localparam int SE_SLOT_ON = 7;
  localparam int SE_SPECIAL_LOCK = 5;
  localparam int SE_IDENT_WP = 4;
  localparam int BD_BUF_OFF = 0;
  localparam int DM_SOFTWARE = 0;
  localparam int CP_SHUTDOWN = 0;
  localparam int CSC_DETECT_CHANGE = 3;
  // Access sequencer states.
  typedef enum logic [1:0] {
    PCSLT_IDLE = 2'b00,
    PCSLT_SETUP = 2'b01,
    PCSLT_STROBE = 2'b10,
    PCSLT_HOLD = 2'b11
  } pcslt_state_e;
endpackage : pcslt_pkg
`default_nettype wire

// >>> rtl/pcslt_regs.sv
// Slot control and configuration register bank of a PC card host controller.
// Assumes a classic Wishbone master on CLK_SYS and synchronous card-side inputs.
`default_nettype none
module pcslt_regs #(
  parameter logic [7:0] IDENT_VALUE = pcslt_pkg::IDENT_RESET
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [pcslt_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [pcslt_pkg::DATA_W-1:0] WB_DAT_I,
  output logic [pcslt_pkg::DATA_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CARD_PRESENT,
  input wire logic [1:0] CARD_VOLTAGE_SENSE_PINS,
  input wire logic [pcslt_pkg::CSC_W-1:0] CARD_STATUS_EVENT,
  input wire logic CARD_RING,
  input wire logic CARD_IREQ,
  input wire logic CARD_ACC_REQ,
  output logic CARD_ACC_STROBE,
  output logic CARD_ACC_DONE,
  output logic CSC_IRQ,
  output logic RING_INDICATE_OUT,
  output logic SYSTEM_INTERRUPT_LINE,
  output logic BUFFER_DISABLE_N,
  output logic CARD_VCC_3V,
  output logic [1:0] SUPPLY_CTRL_OE
);
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0] ident_q, ident_d, power_q, power_d, addgen_q, addgen_d, global_q, global_d;
  logic [7:0] timing_q, timing_d, spare_q, spare_d, fsel_q, fsel_d, special_q, special_d;
  logic [7:0] slot_q, slot_d, bufdis_q, bufdis_d, detect_q, detect_d, cpwr_q, cpwr_d;
  logic [3:0] csc_q, csc_d;
  logic present_q, present_d;
  logic [7:0] rd_val;
  logic req, wr, rd, slot_on, lock, timing_en, present_now, removal;
  logic ring_d, irql_d, bufn_d, vcc3_d, cscirq_d;
  logic [1:0] oe_d;
  logic ring_q, irql_q, bufn_q, vcc3_q, cscirq_q;
  logic [1:0] oe_q;
  pcslt_pkg::pcslt_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic strobe_q, strobe_d, done_q, done_d;

  // Tells whether a byte offset lies in the per-slot register set.
  function automatic logic in_slot_set(input logic [8:0] a);
    in_slot_set = (a <= pcslt_pkg::OFS_SLOT_LAST);
  endfunction : in_slot_set

  // Bus request decode; a request is taken while no acknowledge is pending.
  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr = req & WB_WE_I & WB_SEL_I[0];
  assign rd = req & ~WB_WE_I;
  assign slot_on = slot_q[pcslt_pkg::SE_SLOT_ON];
  assign lock = slot_q[pcslt_pkg::SE_SPECIAL_LOCK];
  assign timing_en = fsel_q[pcslt_pkg::FS_TIMING_EN];
  assign present_now = detect_q[pcslt_pkg::DM_SOFTWARE] | CARD_PRESENT;
  assign removal = present_q & ~present_now;

  // Read value for the addressed register.
  always_comb begin
    rd_val = pcslt_pkg::RD_ZERO;
    if (in_slot_set(WB_ADR_I) && !slot_on) begin
      rd_val = pcslt_pkg::RD_ZERO;
    end else begin
      case ({WB_ADR_I[8:pcslt_pkg::WORD_LSB], 2'b00})
        pcslt_pkg::OFS_IDENT: rd_val = ident_q;
        pcslt_pkg::OFS_POWER: rd_val = power_q;
        pcslt_pkg::OFS_CSC: rd_val = {4'h0, csc_q};
        pcslt_pkg::OFS_ADD_GEN: begin
          rd_val = addgen_q;
          if (fsel_q[pcslt_pkg::FS_VS_EN]) begin
            rd_val[pcslt_pkg::AG_VS_HI:pcslt_pkg::AG_VS_LO] = CARD_VOLTAGE_SENSE_PINS;
          end
        end
        pcslt_pkg::OFS_FIXED: rd_val = pcslt_pkg::FIXED_VALUE;
        pcslt_pkg::OFS_GLOBAL: rd_val = global_q;
        pcslt_pkg::OFS_TIMING: begin
          rd_val = timing_en ? {1'b1, timing_q[6:0]} : pcslt_pkg::RD_ZERO;
        end
        pcslt_pkg::OFS_SPARE: rd_val = spare_q;
        pcslt_pkg::OFS_FUNC_SEL: rd_val = lock ? pcslt_pkg::RD_ZERO : fsel_q;
        pcslt_pkg::OFS_SPECIAL: rd_val = special_q;
        pcslt_pkg::OFS_SLOT_EN: rd_val = slot_q;
        pcslt_pkg::OFS_BUF_DIS: rd_val = bufdis_q;
        pcslt_pkg::OFS_DETECT: rd_val = detect_q;
        pcslt_pkg::OFS_COMMON_PWR: rd_val = cpwr_q;
        default: rd_val = pcslt_pkg::RD_ZERO;
      endcase
    end
  end

  // Register next values: bus writes, hardware events and slot-off defaults.
  always_comb begin
    logic [8:0] wa;
    logic [7:0] wd;
    wa = {WB_ADR_I[8:pcslt_pkg::WORD_LSB], 2'b00};
    wd = WB_DAT_I[7:0];
    ack_d = req;
    dat_d = rd ? {24'h000000, rd_val} : 32'h00000000;
    ident_d = ident_q;
    power_d = power_q;
    addgen_d = addgen_q;
    global_d = global_q;
    timing_d = timing_q;
    spare_d = spare_q;
    fsel_d = fsel_q;
    special_d = special_q;
    slot_d = slot_q;
    bufdis_d = bufdis_q;
    detect_d = detect_q;
    cpwr_d = cpwr_q;
    csc_d = csc_q;
    present_d = present_now;
    // Status change bits: read clear or write-one clear, then events set.
    if (rd && wa == pcslt_pkg::OFS_CSC && slot_on && !global_q[pcslt_pkg::GC_EXPLICIT_WB]) begin
      csc_d = 4'h0;
    end
    if (wr && slot_on) begin
      case (wa)
        pcslt_pkg::OFS_IDENT: begin
          if (!slot_q[pcslt_pkg::SE_IDENT_WP]) ident_d = wd;
        end
        pcslt_pkg::OFS_POWER: power_d = wd;
        pcslt_pkg::OFS_CSC: begin
          if (global_q[pcslt_pkg::GC_EXPLICIT_WB]) csc_d = csc_q & ~wd[3:0];
        end
        pcslt_pkg::OFS_ADD_GEN: addgen_d = wd;
        pcslt_pkg::OFS_GLOBAL: global_d = wd;
        pcslt_pkg::OFS_TIMING: begin
          if (!lock) timing_d = wd;
        end
        pcslt_pkg::OFS_SPARE: spare_d = wd;
        pcslt_pkg::OFS_FUNC_SEL: begin
          if (!lock) fsel_d = wd;
        end
        pcslt_pkg::OFS_SPECIAL: begin
          if (!lock) begin
            special_d = {wd[7:2], special_q[pcslt_pkg::SO_REMOVAL], wd[0]};
          end
        end
        default: begin
        end
      endcase
    end
    if (wr) begin
      case (wa)
        pcslt_pkg::OFS_SLOT_EN: slot_d = wd;
        pcslt_pkg::OFS_BUF_DIS: bufdis_d = wd;
        pcslt_pkg::OFS_DETECT: detect_d = wd;
        pcslt_pkg::OFS_COMMON_PWR: cpwr_d = wd;
        default: begin
        end
      endcase
    end
    csc_d = csc_d | CARD_STATUS_EVENT;
    if (removal) begin
      special_d[pcslt_pkg::SO_REMOVAL] = 1'b1;
      csc_d[pcslt_pkg::CSC_DETECT_CHANGE] = 1'b1;
    end
    if (!slot_on) begin
      ident_d = IDENT_VALUE;
      power_d = pcslt_pkg::RST_REG;
      csc_d = 4'h0;
      addgen_d = pcslt_pkg::RST_REG;
      global_d = pcslt_pkg::RST_REG;
      timing_d = pcslt_pkg::RST_REG;
      spare_d = pcslt_pkg::RST_REG;
      fsel_d = pcslt_pkg::RST_REG;
      special_d = pcslt_pkg::RST_REG;
    end
  end

  // Bus answer and register storage.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      ident_q <= IDENT_VALUE;
      power_q <= pcslt_pkg::RST_REG;
      addgen_q <= pcslt_pkg::RST_REG;
      global_q <= pcslt_pkg::RST_REG;
      timing_q <= pcslt_pkg::RST_REG;
      spare_q <= pcslt_pkg::RST_REG;
      fsel_q <= pcslt_pkg::RST_REG;
      special_q <= pcslt_pkg::RST_REG;
      slot_q <= pcslt_pkg::RST_REG;
      bufdis_q <= pcslt_pkg::RST_REG;
      detect_q <= pcslt_pkg::RST_REG;
      cpwr_q <= pcslt_pkg::RST_REG;
      csc_q <= 4'h0;
      present_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      ident_q <= ident_d;
      power_q <= power_d;
      addgen_q <= addgen_d;
      global_q <= global_d;
      timing_q <= timing_d;
      spare_q <= spare_d;
      fsel_q <= fsel_d;
      special_q <= special_d;
      slot_q <= slot_d;
      bufdis_q <= bufdis_d;
      detect_q <= detect_d;
      cpwr_q <= cpwr_d;
      csc_q <= csc_d;
      present_q <= present_d;
    end
  end

  // Card access sequencer: setup waits, one strobe cycle, hold waits.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    strobe_d = 1'b0;
    done_d = 1'b0;
    case (st_q)
      pcslt_pkg::PCSLT_IDLE: begin
        if (CARD_ACC_REQ && slot_on) begin
          st_d = pcslt_pkg::PCSLT_SETUP;
          cnt_d = timing_en ? {2'b00, timing_q[pcslt_pkg::TM_SETUP_HI:pcslt_pkg::TM_SETUP_LO]} : 4'h0;
        end
      end
      pcslt_pkg::PCSLT_SETUP: begin
        if (cnt_q == 4'h0) begin
          st_d = pcslt_pkg::PCSLT_STROBE;
          strobe_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      pcslt_pkg::PCSLT_STROBE: begin
        st_d = pcslt_pkg::PCSLT_HOLD;
        cnt_d = timing_en ? timing_q[pcslt_pkg::TM_HOLD_HI:pcslt_pkg::TM_HOLD_LO] : 4'h0;
      end
      pcslt_pkg::PCSLT_HOLD: begin
        if (cnt_q == 4'h0) begin
          st_d = pcslt_pkg::PCSLT_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: st_d = pcslt_pkg::PCSLT_IDLE;
    endcase
  end

  // Card side pins, each taken from a flip-flop.
  always_comb begin
    cscirq_d = |csc_q;
    ring_d = CARD_RING & ~(fsel_q[pcslt_pkg::FS_BUF_PWR_EN] & bufdis_q[pcslt_pkg::BD_BUF_OFF]);
    irql_d = special_q[pcslt_pkg::SO_PULSE_MODE] ? CARD_IREQ : ~CARD_IREQ;
    bufn_d = special_q[pcslt_pkg::SO_BUF_CTRL] | ~bufdis_q[pcslt_pkg::BD_BUF_OFF];
    vcc3_d = fsel_q[pcslt_pkg::FS_CARD_PWR_EN] & power_q[pcslt_pkg::PWR_VCC_3V];
    oe_d = {2{~cpwr_q[pcslt_pkg::CP_SHUTDOWN]}};
  end

  // Sequencer and pin registers.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q <= pcslt_pkg::PCSLT_IDLE;
      cnt_q <= 4'h0;
      strobe_q <= 1'b0;
      done_q <= 1'b0;
      cscirq_q <= 1'b0;
      ring_q <= 1'b0;
      irql_q <= 1'b0;
      bufn_q <= 1'b1;
      vcc3_q <= 1'b0;
      oe_q <= 2'b11;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      strobe_q <= strobe_d;
      done_q <= done_d;
      cscirq_q <= cscirq_d;
      ring_q <= ring_d;
      irql_q <= irql_d;
      bufn_q <= bufn_d;
      vcc3_q <= vcc3_d;
      oe_q <= oe_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign CARD_ACC_STROBE = strobe_q;
  assign CARD_ACC_DONE = done_q;
  assign CSC_IRQ = cscirq_q;
  assign RING_INDICATE_OUT = ring_q;
  assign SYSTEM_INTERRUPT_LINE = irql_q;
  assign BUFFER_DISABLE_N = bufn_q;
  assign CARD_VCC_3V = vcc3_q;
  assign SUPPLY_CTRL_OE = oe_q;

  // Checks on the behaviour above.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_csc_read;
    rd && slot_on && {WB_ADR_I[8:2], 2'b00} == pcslt_pkg::OFS_CSC;
  endsequence
  property p_explicit_no_clear;
    (s_csc_read and global_q[pcslt_pkg::GC_EXPLICIT_WB]) |=> ((csc_q & $past(csc_q)) == $past(csc_q));
  endproperty
  a_explicit_no_clear: assert property (p_explicit_no_clear) else $error("Status bits cleared by read.");
  property p_irq_holds;
    (|csc_q) |=> CSC_IRQ;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("Status interrupt dropped early.");
  property p_timing_lock;
    (wr && lock && {WB_ADR_I[8:2], 2'b00} == pcslt_pkg::OFS_TIMING) |=> $stable(timing_q);
  endproperty
  a_timing_lock: assert property (p_timing_lock) else $error("Locked timing register written.");
  property p_timing_read;
    (rd && slot_on && {WB_ADR_I[8:2], 2'b00} == pcslt_pkg::OFS_TIMING)
      |=> WB_ACK_O && WB_DAT_O[7] == $past(timing_en) && ($past(timing_en) || WB_DAT_O == 32'h0);
  endproperty
  a_timing_read: assert property (p_timing_read) else $error("Timing register read value wrong.");
  sequence s_zero_setup;
    st_q == pcslt_pkg::PCSLT_IDLE && CARD_ACC_REQ && slot_on && !timing_en;
  endsequence
  property p_no_wait_access;
    s_zero_setup |=> ##1 CARD_ACC_STROBE ##2 CARD_ACC_DONE;
  endproperty
  a_no_wait_access: assert property (p_no_wait_access) else $error("Untimed access length wrong.");
  property p_hold_length;
    (st_q == pcslt_pkg::PCSLT_STROBE && timing_en && timing_q[3:0] == 4'h3) |=> !CARD_ACC_DONE [*4] ##1 CARD_ACC_DONE;
  endproperty
  a_hold_length: assert property (p_hold_length) else $error("Hold waits miscounted.");
  property p_ring_forced;
    (fsel_q[pcslt_pkg::FS_BUF_PWR_EN] && bufdis_q[pcslt_pkg::BD_BUF_OFF]) |=> !RING_INDICATE_OUT;
  endproperty
  a_ring_forced: assert property (p_ring_forced) else $error("Ring indicate not forced low.");
  property p_irq_polarity;
    !RST |=> SYSTEM_INTERRUPT_LINE == ($past(CARD_IREQ) ~^ $past(special_q[pcslt_pkg::SO_PULSE_MODE]));
  endproperty
  a_irq_polarity: assert property (p_irq_polarity) else $error("Interrupt line polarity wrong.");
  property p_slot_off_default;
    !slot_on |=> ##1 (!slot_on -> fsel_q == pcslt_pkg::RST_REG && special_q == pcslt_pkg::RST_REG);
  endproperty
  a_slot_off_default: assert property (p_slot_off_default) else $error("Slot registers not held.");
  property p_fixed_read;
    (rd && {WB_ADR_I[8:2], 2'b00} == pcslt_pkg::OFS_FIXED && slot_on) |=> WB_DAT_O == 32'h0000000f;
  endproperty
  a_fixed_read: assert property (p_fixed_read) else $error("Fixed offset read wrong.");
  property p_shutdown;
    cpwr_q[pcslt_pkg::CP_SHUTDOWN] |=> SUPPLY_CTRL_OE == 2'b00;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("Supplies not floated.");
endmodule : pcslt_regs
`default_nettype wire

// >>> bench/pcslt_card_model.sv
// Behavioural model of the PC card that sits in the slot.
// Assumes the bench calls its tasks between clock edges; pins change just after a rising edge.
`default_nettype none
module pcslt_card_model (
  input wire logic CLK_SYS,
  output logic CARD_PRESENT,
  output logic [1:0] CARD_VOLTAGE_SENSE_PINS,
  output logic [pcslt_pkg::CSC_W-1:0] CARD_STATUS_EVENT,
  output logic CARD_RING,
  output logic CARD_IREQ
);
  timeunit 1ns;
  timeprecision 100ps;

  // The slot starts empty and quiet.
  initial begin
    CARD_PRESENT = 1'b0;
    CARD_VOLTAGE_SENSE_PINS = 2'b00;
    CARD_STATUS_EVENT = '0;
    CARD_RING = 1'b0;
    CARD_IREQ = 1'b0;
  end

  // Moves the level pins of the card together, as an insertion or a removal would.
  task automatic pins(input logic p, input logic [1:0] vs, input logic r, input logic i);
    @(posedge CLK_SYS);
    CARD_PRESENT <= p;
    CARD_VOLTAGE_SENSE_PINS <= vs;
    CARD_RING <= r;
    CARD_IREQ <= i;
  endtask : pins

  // Raises status events for exactly one clock, since the host sees them as pulses.
  task automatic pulse(input logic [pcslt_pkg::CSC_W-1:0] e);
    @(posedge CLK_SYS);
    CARD_STATUS_EVENT <= e;
    @(posedge CLK_SYS);
    CARD_STATUS_EVENT <= '0;
  endtask : pulse
endmodule : pcslt_card_model
`default_nettype wire

// >>> bench/pcslt_regs_tb.sv
// Self-checking bench for the slot control register bank.
// Assumes a classic Wishbone master and the card model drive every design input.
`default_nettype none
module pcslt_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat_w = '0;
  logic [31:0] dat_r;
  logic ack;
  logic req = 1'b0;
  logic present, ring, ireq, strobe, done, csc_irq, ring_out, sys_irq, buf_n, vcc3;
  logic [1:0] vs;
  logic [1:0] oe;
  logic [3:0] ev;
  logic [7:0] q;
  int n_errors = 0;
  int checks_done = 0;

  // The clock toggles every half period of 12.5 ns.
  always #12.5 clk_sys = ~clk_sys;

  pcslt_regs pcslt_regs_i (.CLK_SYS(clk_sys), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .CARD_PRESENT(present), .CARD_VOLTAGE_SENSE_PINS(vs), .CARD_STATUS_EVENT(ev), .CARD_RING(ring),
    .CARD_IREQ(ireq), .CARD_ACC_REQ(req), .CARD_ACC_STROBE(strobe), .CARD_ACC_DONE(done),
    .CSC_IRQ(csc_irq), .RING_INDICATE_OUT(ring_out), .SYSTEM_INTERRUPT_LINE(sys_irq),
    .BUFFER_DISABLE_N(buf_n), .CARD_VCC_3V(vcc3), .SUPPLY_CTRL_OE(oe));

  pcslt_card_model pcslt_card_model_i (.CLK_SYS(clk_sys), .CARD_PRESENT(present),
    .CARD_VOLTAGE_SENSE_PINS(vs), .CARD_STATUS_EVENT(ev), .CARD_RING(ring), .CARD_IREQ(ireq));

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // Compares a seen value with the expected one.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; request held until ack is sampled high.
  task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = dat_r[7:0];
    if (n >= 20) chk(8'h00, 8'hff);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [8:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rc

  // Lets registered pin outputs follow a change at their inputs.
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  // Requests one card access and counts cycles to the strobe and to the end of hold.
  task automatic acc(input int su, input int ho);
    int n;
    @(posedge clk_sys);
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (strobe !== 1'b1 && n < 40);
    // The strobe follows one base setup cycle after the taking edge, plus the setup waits.
    chk(8'(n), 8'(1 + su));
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'b1 && n < 40);
    chk(8'(n), 8'(2 + ho));
  endtask : acc

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end

  // Main sequence of register and pin tests.
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rc(pcslt_pkg::OFS_SLOT_EN, 8'h00);
    wr(pcslt_pkg::OFS_SPARE, 8'h3c);
    rc(pcslt_pkg::OFS_SPARE, 8'h00);
    wr(pcslt_pkg::OFS_SLOT_EN, 8'h80);
    wr(pcslt_pkg::OFS_SPARE, 8'ha5);
    rc(pcslt_pkg::OFS_SPARE, 8'ha5);
    rc(9'h0e0, 8'h00);
    rc(pcslt_pkg::OFS_FIXED, pcslt_pkg::FIXED_VALUE);
    wr(pcslt_pkg::OFS_TIMING, 8'h35);
    rc(pcslt_pkg::OFS_TIMING, 8'h00);
    acc(0, 0);
    wr(pcslt_pkg::OFS_FUNC_SEL, 8'h08);
    rc(pcslt_pkg::OFS_FUNC_SEL, 8'h08);
    rc(pcslt_pkg::OFS_TIMING, 8'hb5);
    // Every setup code, with hold counts of zero, five, ten and fifteen.
    for (int s = 0; s < 4; s++) begin
      wr(pcslt_pkg::OFS_TIMING, {2'b00, 2'(s), 4'(s * 5)});
      acc(s, s * 5);
    end
    // A hold of three waits exercises the counted hold check as well.
    wr(pcslt_pkg::OFS_TIMING, 8'h03);
    acc(0, 3);
    wr(pcslt_pkg::OFS_IDENT, 8'h11);
    rc(pcslt_pkg::OFS_IDENT, 8'h11);
    wr(pcslt_pkg::OFS_SLOT_EN, 8'h90);
    wr(pcslt_pkg::OFS_IDENT, 8'h22);
    rc(pcslt_pkg::OFS_IDENT, 8'h11);
    pcslt_card_model_i.pins(1'b0, 2'b10, 1'b1, 1'b1);
    settle();
    chk({7'h00, sys_irq}, 8'h00);
    wr(pcslt_pkg::OFS_SPECIAL, 8'h04);
    settle();
    chk({7'h00, sys_irq}, 8'h01);
    wr(pcslt_pkg::OFS_BUF_DIS, 8'h01);
    settle();
    chk({7'h00, buf_n}, 8'h00);
    wr(pcslt_pkg::OFS_SPECIAL, 8'h05);
    settle();
    chk({7'h00, buf_n}, 8'h01);
    chk({7'h00, ring_out}, 8'h01);
    wr(pcslt_pkg::OFS_FUNC_SEL, 8'h48);
    settle();
    chk({7'h00, ring_out}, 8'h00);
    wr(pcslt_pkg::OFS_ADD_GEN, 8'h3c);
    rc(pcslt_pkg::OFS_ADD_GEN, 8'h3c);
    wr(pcslt_pkg::OFS_FUNC_SEL, 8'h4b);
    rc(pcslt_pkg::OFS_ADD_GEN, 8'hbc);
    wr(pcslt_pkg::OFS_POWER, 8'h08);
    settle();
    chk({7'h00, vcc3}, 8'h01);
    wr(pcslt_pkg::OFS_FUNC_SEL, 8'h4a);
    settle();
    chk({7'h00, vcc3}, 8'h00);
    wr(pcslt_pkg::OFS_COMMON_PWR, 8'h01);
    settle();
    chk({6'h00, oe}, 8'h00);
    wr(pcslt_pkg::OFS_COMMON_PWR, 8'h00);
    settle();
    chk({6'h00, oe}, 8'h03);
    // Status bits clear on read until explicit write-back is chosen.
    pcslt_card_model_i.pulse(4'h1);
    rc(pcslt_pkg::OFS_CSC, 8'h01);
    rc(pcslt_pkg::OFS_CSC, 8'h00);
    pcslt_card_model_i.pins(1'b1, 2'b10, 1'b1, 1'b1);
    settle();
    rc(pcslt_pkg::OFS_SPECIAL, 8'h05);
    wb(1'b0, pcslt_pkg::OFS_CSC, 8'h00, q);
    wr(pcslt_pkg::OFS_GLOBAL, 8'h04);
    pcslt_card_model_i.pins(1'b0, 2'b10, 1'b1, 1'b1);
    settle();
    rc(pcslt_pkg::OFS_SPECIAL, 8'h07);
    wr(pcslt_pkg::OFS_SPECIAL, 8'h05);
    rc(pcslt_pkg::OFS_SPECIAL, 8'h07);
    rc(pcslt_pkg::OFS_CSC, 8'h08);
    rc(pcslt_pkg::OFS_CSC, 8'h08);
    chk({7'h00, csc_irq}, 8'h01);
    wr(pcslt_pkg::OFS_CSC, 8'h08);
    rc(pcslt_pkg::OFS_CSC, 8'h00);
    settle();
    chk({7'h00, csc_irq}, 8'h00);
    // Software detection pretends a card, and dropping it looks like a removal.
    wr(pcslt_pkg::OFS_DETECT, 8'h01);
    settle();
    wr(pcslt_pkg::OFS_CSC, 8'h08);
    rc(pcslt_pkg::OFS_ADD_GEN, 8'hbc);
    wr(pcslt_pkg::OFS_DETECT, 8'h00);
    settle();
    rc(pcslt_pkg::OFS_CSC, 8'h08);
    // Locked writes are acknowledged and dropped.
    wr(pcslt_pkg::OFS_SLOT_EN, 8'ha0);
    wr(pcslt_pkg::OFS_TIMING, 8'h0f);
    wr(pcslt_pkg::OFS_FUNC_SEL, 8'h08);
    wr(pcslt_pkg::OFS_SPECIAL, 8'h00);
    rc(pcslt_pkg::OFS_FUNC_SEL, 8'h00);
    rc(pcslt_pkg::OFS_SPECIAL, 8'h07);
    wr(pcslt_pkg::OFS_SLOT_EN, 8'h80);
    rc(pcslt_pkg::OFS_FUNC_SEL, 8'h4a);
    rc(pcslt_pkg::OFS_TIMING, 8'h83);
    // Turning the slot off returns its registers to their reset values.
    wr(pcslt_pkg::OFS_SLOT_EN, 8'h00);
    rc(pcslt_pkg::OFS_SPARE, 8'h00);
    wr(pcslt_pkg::OFS_SLOT_EN, 8'h80);
    rc(pcslt_pkg::OFS_SPARE, 8'h00);
    stop_test();
  end
endmodule : pcslt_regs_tb
`default_nettype wire
